// ### core/uplc_pkg.sv
// Constants for the per-port USB line control block: register offsets,
// field positions, reset values and line force codes.
// Assumes a 16-bit register word addressed by a 16-bit byte address.
package uplc_pkg;
   // ==========================================================
   // Register map
   localparam logic [15:0] UPLC_PORT1_OFS = 16'hc08a;
   localparam logic [15:0] UPLC_PORT2_OFS = 16'hc0aa;
   localparam logic [15:0] UPLC_CTL_RESET = 16'h0000;
   // ==========================================================
   // Field positions
   localparam int UPLC_DP_BIT     = 13;
   localparam int UPLC_DM_BIT     = 12;
   localparam int UPLC_LOWSPD_BIT = 10;
   localparam int UPLC_HOST_BIT   = 9;
   localparam int UPLC_RES_BIT    = 7;
   localparam int UPLC_FORCE_HI   = 4;
   localparam int UPLC_FORCE_LO   = 3;
   localparam int UPLC_SUSP_BIT   = 2;
   localparam int UPLC_SOF_BIT    = 0;
   // Writable bits; reserved and status bits ignore writes
   localparam logic [15:0] UPLC_WR_MASK = 16'h069d;
   // ==========================================================
   // Line force codes
   typedef enum logic [1:0] {
      UPLC_FORCE_NONE = 2'h0,
      UPLC_FORCE_SE0  = 2'h1,
      UPLC_FORCE_J    = 2'h2,
      UPLC_FORCE_K    = 2'h3
   } uplc_force_t;
endpackage

// ### core/uplc_sync.sv
// Two flip-flop level synchroniser for the data line inputs.
// Assumes inputs that may change at any time relative to clk.
`timescale 1ns/10ps
module uplc_sync #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;
   // ==========================================================
   // Synchroniser chain; first stage feeds only the second
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= d;
         q_r    <= meta_r;
      end
   end
   assign q = q_r;
endmodule

// ### core/uplc_top.sv
// Line control and status for the two serial engines, one port each.
// Assumes the on-chip processor and the external processor port share clk,
// and that the transceiver resolves drive enables and resistor controls.
`timescale 1ns/10ps
module uplc_top (
   input  wire logic        clk,
   input  wire logic        resetn,
   // On-chip processor access
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_wr,
   input  wire logic        cpu_rd,
   input  wire logic [15:0] cpu_wdata,
   output logic      [15:0] cpu_rdata,
   output logic             cpu_rvalid,
   // External processor port access
   input  wire logic [15:0] ext_addr,
   input  wire logic        ext_wr,
   input  wire logic        ext_rd,
   input  wire logic [15:0] ext_wdata,
   output logic      [15:0] ext_rdata,
   output logic             ext_rvalid,
   // Serial engine side, bit n for engine n
   input  wire logic [1:0]  eng_dp_out,
   input  wire logic [1:0]  eng_dm_out,
   input  wire logic [1:0]  eng_oe,
   input  wire logic [1:0]  port_select,
   output logic      [1:0]  eng_rx_en,
   output logic      [1:0]  frame_gen_en,
   output logic      [1:0]  frame_low_speed,
   output logic      [1:0]  host_mode,
   output logic      [1:0]  low_speed_select,
   // Line side
   input  wire logic [1:0]  dp_in,
   input  wire logic [1:0]  dm_in,
   output logic      [1:0]  dp_out,
   output logic      [1:0]  dm_out,
   output logic      [1:0]  dp_oe,
   output logic      [1:0]  dm_oe,
   output logic      [1:0]  dp_pullup,
   output logic      [1:0]  dm_pullup,
   output logic      [1:0]  dp_pulldown,
   output logic      [1:0]  dm_pulldown,
   output logic             xcvr_suspend
);
   import uplc_pkg::*;

   logic [15:0] ctl_r [2];
   logic [15:0] ctl_nxt [2];
   logic [15:0] cpu_rdata_r, cpu_rdata_nxt, ext_rdata_r, ext_rdata_nxt;
   logic        cpu_rvalid_r, ext_rvalid_r;
   logic [1:0]  line_dp, line_dm;
   logic [1:0]  dp_out_r, dm_out_r, dp_oe_r, dm_oe_r;
   logic [1:0]  dp_out_nxt, dm_out_nxt, dp_oe_nxt, dm_oe_nxt;
   logic [1:0]  dp_pu_r, dm_pu_r, dp_pd_r, dm_pd_r;
   logic [1:0]  dp_pu_nxt, dm_pu_nxt, dp_pd_nxt, dm_pd_nxt;
   logic [1:0]  rx_en_r, rx_en_nxt, fgen_r, fgen_nxt, flow_r, host_r, lsp_r;
   logic        susp_r, susp_nxt;
   logic [1:0]  cpu_hit, ext_hit;

   // ==========================================================
   // Address decode, shared by both access ports
   function automatic logic [1:0] hit(input logic [15:0] a);
      hit = {a == UPLC_PORT2_OFS, a == UPLC_PORT1_OFS};
   endfunction

   // Read image: status bits live, reserved bits zero
   function automatic logic [15:0] rd_word(input logic [15:0] a, input logic [15:0] c0, input logic [15:0] c1,
                                           input logic [1:0] sdp, input logic [1:0] sdm);
      logic [15:0] w;
      logic [1:0]  h;
      w = 16'h0000;
      h = hit(a);
      if (h[0]) begin
         w = c0 & UPLC_WR_MASK;
         w[UPLC_DP_BIT] = sdp[0];
         w[UPLC_DM_BIT] = sdm[0];
      end else if (h[1]) begin
         w = c1 & UPLC_WR_MASK;
         w[UPLC_DP_BIT] = sdp[1];
         w[UPLC_DM_BIT] = sdm[1];
      end
      rd_word = w;
   endfunction

   // ==========================================================
   // Pin level synchroniser
   // two-stage sync
   uplc_sync #(.W(4)) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      ({dm_in, dp_in}),
      .q      ({line_dm, line_dp})
   );

   // ==========================================================
   // Register writes; on-chip processor wins a same-cycle clash
   // dual access path
   assign cpu_hit = hit(cpu_addr);
   assign ext_hit = hit(ext_addr);
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         ctl_nxt[i] = ctl_r[i];
         if (ext_wr && ext_hit[i]) begin
            ctl_nxt[i] = ext_wdata & UPLC_WR_MASK;
         end
         if (cpu_wr && cpu_hit[i]) begin
            ctl_nxt[i] = cpu_wdata & UPLC_WR_MASK;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctl_r[0] <= UPLC_CTL_RESET;
         ctl_r[1] <= UPLC_CTL_RESET;
      end else begin
         ctl_r[0] <= ctl_nxt[0];
         ctl_r[1] <= ctl_nxt[1];
      end
   end

   // ==========================================================
   // Read data, one cycle after the strobe
   // status readback
   always_comb begin
      cpu_rdata_nxt = cpu_rd ? rd_word(cpu_addr, ctl_r[0], ctl_r[1], line_dp, line_dm) : cpu_rdata_r;
      ext_rdata_nxt = ext_rd ? rd_word(ext_addr, ctl_r[0], ctl_r[1], line_dp, line_dm) : ext_rdata_r;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cpu_rdata_r  <= 16'h0000;
         ext_rdata_r  <= 16'h0000;
         cpu_rvalid_r <= 1'b0;
         ext_rvalid_r <= 1'b0;
      end else begin
         cpu_rdata_r  <= cpu_rdata_nxt;
         ext_rdata_r  <= ext_rdata_nxt;
         cpu_rvalid_r <= cpu_rd;
         ext_rvalid_r <= ext_rd;
      end
   end

   // ==========================================================
   // Line drive, resistors and engine gating
   always_comb begin
      logic [1:0] f;
      logic       ls, hm, re, act;
      f = 2'h0;
      ls = 1'b0;
      hm = 1'b0;
      re = 1'b0;
      act = 1'b0;
      susp_nxt = ctl_nxt[0][UPLC_SUSP_BIT] | ctl_nxt[1][UPLC_SUSP_BIT];
      for (int i = 0; i < 2; i++) begin
         f  = ctl_nxt[i][UPLC_FORCE_HI:UPLC_FORCE_LO];
         ls = ctl_nxt[i][UPLC_LOWSPD_BIT];
         hm = ctl_nxt[i][UPLC_HOST_BIT];
         re = ctl_nxt[i][UPLC_RES_BIT];
         case (uplc_force_t'(f))
            UPLC_FORCE_NONE: begin
               dp_out_nxt[i] = eng_dp_out[i];
               dm_out_nxt[i] = eng_dm_out[i];
               dp_oe_nxt[i]  = eng_oe[i] & ~susp_nxt;
            end
            UPLC_FORCE_SE0: begin
               dp_out_nxt[i] = 1'b0;
               dm_out_nxt[i] = 1'b0;
               dp_oe_nxt[i]  = 1'b1;
            end
            UPLC_FORCE_J: begin
               dp_out_nxt[i] = ~ls;  // J is D+ high at full speed
               dm_out_nxt[i] = ls;
               dp_oe_nxt[i]  = 1'b1;
            end
            default: begin
               dp_out_nxt[i] = ls;
               dm_out_nxt[i] = ~ls;
               dp_oe_nxt[i]  = 1'b1;
            end
         endcase
         dm_oe_nxt[i] = dp_oe_nxt[i];
         dp_pd_nxt[i] = re & hm;
         dm_pd_nxt[i] = re & hm;
         dp_pu_nxt[i] = re & ~hm & ~ls;
         dm_pu_nxt[i] = re & ~hm & ls;
         // device role serves only the selected port
         act = ~susp_nxt & (hm | port_select[i]);
         rx_en_nxt[i] = act;
         // frame marker gate, ignored outside host role
         fgen_nxt[i] = hm & ctl_nxt[i][UPLC_SOF_BIT] & act & (f == 2'h0);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dp_out_r <= 2'h0;
         dm_out_r <= 2'h0;
         dp_oe_r  <= 2'h0;
         dm_oe_r  <= 2'h0;
         dp_pu_r  <= 2'h0;
         dm_pu_r  <= 2'h0;
         dp_pd_r  <= 2'h0;
         dm_pd_r  <= 2'h0;
         rx_en_r  <= 2'h0;
         fgen_r   <= 2'h0;
         flow_r   <= 2'h0;
         host_r   <= 2'h0;
         lsp_r    <= 2'h0;
         susp_r   <= 1'b0;
      end else begin
         dp_out_r <= dp_out_nxt;
         dm_out_r <= dm_out_nxt;
         dp_oe_r  <= dp_oe_nxt;
         dm_oe_r  <= dm_oe_nxt;
         dp_pu_r  <= dp_pu_nxt;
         dm_pu_r  <= dm_pu_nxt;
         dp_pd_r  <= dp_pd_nxt;
         dm_pd_r  <= dm_pd_nxt;
         rx_en_r  <= rx_en_nxt;
         fgen_r   <= fgen_nxt;
         flow_r   <= {ctl_nxt[1][UPLC_LOWSPD_BIT], ctl_nxt[0][UPLC_LOWSPD_BIT]};
         host_r   <= {ctl_nxt[1][UPLC_HOST_BIT], ctl_nxt[0][UPLC_HOST_BIT]};
         lsp_r    <= {ctl_nxt[1][UPLC_LOWSPD_BIT], ctl_nxt[0][UPLC_LOWSPD_BIT]};
         susp_r   <= susp_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign cpu_rdata        = cpu_rdata_r;
   assign cpu_rvalid       = cpu_rvalid_r;
   assign ext_rdata        = ext_rdata_r;
   assign ext_rvalid       = ext_rvalid_r;
   assign dp_out           = dp_out_r;
   assign dm_out           = dm_out_r;
   assign dp_oe            = dp_oe_r;
   assign dm_oe            = dm_oe_r;
   assign dp_pullup        = dp_pu_r;
   assign dm_pullup        = dm_pu_r;
   assign dp_pulldown      = dp_pd_r;
   assign dm_pulldown      = dm_pd_r;
   assign eng_rx_en        = rx_en_r;
   assign frame_gen_en     = fgen_r;
   assign frame_low_speed  = flow_r;
   assign host_mode        = host_r;
   assign low_speed_select = lsp_r;
   assign xcvr_suspend     = susp_r;

   // ==========================================================
   // Checks on outputs against register contents and pin inputs
   res_off_a: assert property (@(posedge clk) disable iff (!resetn)
      !ctl_r[0][UPLC_RES_BIT] |-> !(dp_pu_r[0] | dm_pu_r[0] | dp_pd_r[0] | dm_pd_r[0]))
      else $error("termination on while resistors disabled");
   host_pd_a: assert property (@(posedge clk) disable iff (!resetn)
      (ctl_r[1][UPLC_RES_BIT] && ctl_r[1][UPLC_HOST_BIT]) |-> (dp_pd_r[1] && dm_pd_r[1] && !dp_pu_r[1]))
      else $error("host pull-downs missing");
   dev_pu_a: assert property (@(posedge clk) disable iff (!resetn)
      (ctl_r[0][UPLC_RES_BIT] && !ctl_r[0][UPLC_HOST_BIT]) |->
      (dm_pu_r[0] == ctl_r[0][UPLC_LOWSPD_BIT]) && (dp_pu_r[0] != ctl_r[0][UPLC_LOWSPD_BIT]))
      else $error("device pull-up on wrong line");
   force_se0_a: assert property (@(posedge clk) disable iff (!resetn)
      (ctl_r[1][UPLC_FORCE_HI:UPLC_FORCE_LO] == 2'h1) |-> (dp_oe_r[1] && !dp_out_r[1] && !dm_out_r[1]))
      else $error("SE0 not forced");
   force_k_a: assert property (@(posedge clk) disable iff (!resetn)
      (ctl_r[1][UPLC_FORCE_HI:UPLC_FORCE_LO] == 2'h3 && !ctl_r[1][UPLC_LOWSPD_BIT]) |->
      (dm_oe_r[1] && !dp_out_r[1] && dm_out_r[1]))
      else $error("K not forced regardless of port select");
   susp_both_a: assert property (@(posedge clk) disable iff (!resetn)
      xcvr_suspend |-> (eng_rx_en == 2'h0) && (frame_gen_en == 2'h0))
      else $error("engine active during suspend");
   frame_gate_a: assert property (@(posedge clk) disable iff (!resetn)
      frame_gen_en[1] |-> ctl_r[1][UPLC_HOST_BIT] && ctl_r[1][UPLC_SOF_BIT] &&
      frame_low_speed[1] == ctl_r[1][UPLC_LOWSPD_BIT])
      else $error("frame marker gate wrong");
   dev_port_a: assert property (@(posedge clk) disable iff (!resetn)
      (!ctl_nxt[0][UPLC_HOST_BIT] && !port_select[0]) |=> !eng_rx_en[0])
      else $error("unselected port active in device role");
   wr_rd_a: assert property (@(posedge clk) disable iff (!resetn)
      (ext_wr && ext_addr == UPLC_PORT2_OFS && !cpu_wr) ##1 (cpu_rd && cpu_addr == UPLC_PORT2_OFS)
      |=> cpu_rvalid && cpu_rdata[UPLC_HOST_BIT] == $past(ext_wdata[UPLC_HOST_BIT], 2))
      else $error("external write not visible to processor");
   stat_dp_a: assert property (@(posedge clk) disable iff (!resetn)
      (cpu_rd && cpu_addr == UPLC_PORT1_OFS) |=> cpu_rdata[UPLC_DP_BIT] == $past(dp_in[0], 3))
      else $error("D+ status not two-stage synchronised");
   stat_dm_a: assert property (@(posedge clk) disable iff (!resetn)
      (ext_rd && ext_addr == UPLC_PORT2_OFS) |=> ext_rdata[UPLC_DM_BIT] == $past(dm_in[1], 3))
      else $error("D- status not two-stage synchronised");
endmodule

// ### sim/uplc_line_partner.sv
// Cable partner for both ports: works out each data line from design drive,
// far-end drive and the termination resistors.
// Assumes the bench sets the far-end drive; this model has no clock of its own.
`timescale 1ns/10ps
module uplc_line_partner (
   input  wire logic [1:0] dp_out,
   input  wire logic [1:0] dm_out,
   input  wire logic [1:0] dp_oe,
   input  wire logic [1:0] dm_oe,
   input  wire logic [1:0] dp_pullup,
   input  wire logic [1:0] dm_pullup,
   input  wire logic [1:0] dp_pulldown,
   input  wire logic [1:0] dm_pulldown,
   input  wire logic [1:0] far_drive,
   input  wire logic [1:0] far_dp,
   input  wire logic [1:0] far_dm,
   output logic      [1:0] dp_in,
   output logic      [1:0] dm_in
);
   // ======================================================
   // Line resolution
   logic float_r;
   // Unterminated, undriven lines wander so no stale level passes as valid
   initial begin
      float_r = 1'b0;
      // Offset from the clock edges so the synchroniser never races it
      #7;
      forever #20 float_r = ~float_r;
   end
   // Design drive beats far end, which beats a resistor
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         dp_in[i] = dp_oe[i] ? dp_out[i] : far_drive[i] ? far_dp[i] :
                    dp_pullup[i] ? 1'b1 : dp_pulldown[i] ? 1'b0 : float_r;
         dm_in[i] = dm_oe[i] ? dm_out[i] : far_drive[i] ? far_dm[i] :
                    dm_pullup[i] ? 1'b1 : dm_pulldown[i] ? 1'b0 : ~float_r;
      end
   end
endmodule

// ### sim/tb_usb_port_line_control.sv
// Self-checking bench for the two-port line control block.
// Assumes the cable partner model and the design's package are compiled first.
`timescale 1ns/10ps
module tb_usb_port_line_control;
   import uplc_pkg::*;
   logic        clk, resetn, cpu_wr, cpu_rd, cpu_rvalid, ext_wr, ext_rd, ext_rvalid, xcvr_suspend;
   logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, ext_addr, ext_wdata, ext_rdata, v;
   logic [1:0]  eng_dp_out, eng_dm_out, eng_oe, port_select, eng_rx_en, frame_gen_en, frame_low_speed;
   logic [1:0]  host_mode, low_speed_select, dp_in, dm_in, dp_out, dm_out, dp_oe, dm_oe;
   logic [1:0]  dp_pullup, dm_pullup, dp_pulldown, dm_pulldown, far_drive, far_dp, far_dm, f;
   logic        ls, host, res, xp, xm;
   int          n_mismatch, checks;

   uplc_top uut (.clk, .resetn, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .cpu_rvalid,
      .ext_addr, .ext_wr, .ext_rd, .ext_wdata, .ext_rdata, .ext_rvalid, .eng_dp_out, .eng_dm_out,
      .eng_oe, .port_select, .eng_rx_en, .frame_gen_en, .frame_low_speed, .host_mode, .low_speed_select,
      .dp_in, .dm_in, .dp_out, .dm_out, .dp_oe, .dm_oe, .dp_pullup, .dm_pullup, .dp_pulldown,
      .dm_pulldown, .xcvr_suspend);
   uplc_line_partner far_end (.dp_out, .dm_out, .dp_oe, .dm_oe, .dp_pullup, .dm_pullup, .dp_pulldown,
      .dm_pulldown, .far_drive, .far_dp, .far_dm, .dp_in, .dm_in);

   // ======================================================
   // Clock, helpers and bus tasks
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [15:0] ofs(input int p);
      return p[0] ? UPLC_PORT2_OFS : UPLC_PORT1_OFS;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Write lands at the second edge; outputs are settled on return
   task automatic wr(input bit e, input logic [15:0] a, input logic [15:0] d);
      @(posedge clk); #1;
      if (e) begin ext_addr = a; ext_wdata = d; ext_wr = 1'b1; end
      else begin cpu_addr = a; cpu_wdata = d; cpu_wr = 1'b1; end
      @(posedge clk); #1;
      cpu_wr = 1'b0;
      ext_wr = 1'b0;
   endtask
   // Idle edges first so the pin levels have crossed the synchroniser
   task automatic rd(input bit e, input logic [15:0] a, input logic [15:0] exp);
      repeat (3) @(posedge clk);
      #1;
      if (e) begin ext_addr = a; ext_rd = 1'b1; end
      else begin cpu_addr = a; cpu_rd = 1'b1; end
      @(posedge clk); #1;
      cpu_rd = 1'b0;
      ext_rd = 1'b0;
      chk(e ? ext_rvalid : cpu_rvalid, 16'h0001);
      chk(e ? ext_rdata : cpu_rdata, exp);
   endtask
   task automatic wrap_up;
      $display("TB: %0d compares, %0d mismatches", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Run needs about 140 cycles; 20000 means a hang
   initial begin
      #800000;
      n_mismatch++;
      wrap_up();
   end

   // ======================================================
   // Test sequence
   initial begin
      {cpu_wr, cpu_rd, ext_wr, ext_rd, cpu_addr, cpu_wdata, ext_addr, ext_wdata} = '0;
      {eng_dp_out, eng_dm_out, eng_oe, port_select} = '0;
      far_drive = 2'h3; far_dp = 2'h3; far_dm = 2'h0;
      n_mismatch = 0; checks = 0; resetn = 1'b0;
      repeat (5) @(posedge clk);
      #1 resetn = 1'b1;
      // Reset image and live line status on both buses
      for (int p = 0; p < 4; p++) rd(p[1], ofs(p), 16'h2000);
      far_dp = 2'h0; far_dm = 2'h3;
      for (int p = 0; p < 4; p++) rd(p[1], ofs(p), 16'h1000);
      rd(1'b0, 16'hc08c, 16'h0000);
      $display("test reset_status done");
      // Resistor table, role and speed on every combination
      for (int i = 0; i < 16; i++) begin
         ls = i[3]; host = i[2]; res = i[1];
         wr(i[0], ofs(i), {5'h00, ls, host, 1'b0, res, 7'h00});
         chk(dp_pullup[i[0]], res & ~host & ~ls);
         chk(dm_pullup[i[0]], res & ~host & ls);
         chk(dp_pulldown[i[0]], res & host);
         chk(dm_pulldown[i[0]], res & host);
         chk(host_mode[i[0]], host);
         chk(low_speed_select[i[0]], ls);
         chk(frame_gen_en[i[0]], 1'b0);
      end
      $display("test resistors done");
      // Force codes on port 2 in device role with its port unselected
      far_drive = 2'h0;
      for (int i = 0; i < 8; i++) begin
         ls = i[2]; f = i[1:0];
         v = {5'h00, ls, 5'h00, f, 3'h0};
         xp = (f == 2'h1) ? 1'b0 : (f == 2'h2) ? ~ls : ls;
         xm = (f == 2'h1) ? 1'b0 : ~xp;
         wr(1'b0, ofs(1), v);
         chk(dp_oe[1], f != 2'h0);
         chk(dm_oe[1], f != 2'h0);
         if (f != 2'h0) begin
            chk({dp_out[1], dm_out[1]}, {xp, xm});
            rd(1'b1, ofs(1), v | {2'h0, xp, xm, 12'h000});
         end
      end
      // Every writable bit set; suspend from one register stops both ports
      wr(1'b0, ofs(0), 16'h069d);
      rd(1'b0, ofs(0), 16'h269d);
      chk(xcvr_suspend, 1'b1);
      chk(eng_rx_en, 2'h0);
      chk(dp_oe[0], 1'b1);
      $display("test force_suspend done");
      // Normal engine drive, port select and frame marker gating
      wr(1'b0, ofs(0), 16'h0000);
      wr(1'b0, ofs(1), 16'h0000);
      port_select = 2'h1; eng_oe = 2'h3; eng_dp_out = 2'h1; eng_dm_out = 2'h2;
      @(posedge clk); #1;
      chk(dp_oe, 2'h3);
      chk({dp_out, dm_out}, 4'h6);
      chk(eng_rx_en, 2'h1);
      wr(1'b1, ofs(1), 16'h0201);
      chk(frame_gen_en, 2'h2);
      chk(frame_low_speed[1], 1'b0);
      chk(eng_rx_en, 2'h3);
      wr(1'b1, ofs(1), 16'h0601);
      chk(frame_low_speed[1], 1'b1);
      wr(1'b1, ofs(1), 16'h0609);
      chk(frame_gen_en[1], 1'b0);
      wr(1'b0, ofs(0), 16'h0004);
      chk(dp_oe[0], 1'b0);
      chk(eng_rx_en, 2'h0);
      $display("test drive_frame done");
      // Same-edge writes from both buses: on-chip processor wins
      @(posedge clk); #1;
      cpu_addr = ofs(0); cpu_wdata = 16'h0200; cpu_wr = 1'b1;
      ext_addr = ofs(0); ext_wdata = 16'h0400; ext_wr = 1'b1;
      @(posedge clk); #1;
      cpu_wr = 1'b0;
      ext_wr = 1'b0;
      chk({host_mode[0], low_speed_select[0]}, 2'h2);
      // External write, processor read of it in the very next cycle
      @(posedge clk); #1;
      ext_addr = ofs(1); ext_wdata = 16'h0200; ext_wr = 1'b1;
      @(posedge clk); #1;
      ext_wr = 1'b0;
      cpu_addr = ofs(1); cpu_rd = 1'b1;
      @(posedge clk); #1;
      cpu_rd = 1'b0;
      chk(cpu_rvalid, 16'h0001);
      chk(cpu_rdata, 16'h0200);
      resetn = 1'b0;
      #5;
      chk({host_mode, xcvr_suspend}, 3'h0);
      $display("test collision_reset done");
      wrap_up();
   end
endmodule
